/* hdl/clkgen_pins_pkg.sv */
// constants, pin map, register map and state codes of the clock generator control pins
`default_nettype none
package clkgen_pins_pkg;

  // ==========================================================
  // pin map of the synchronised input vector
  localparam int unsigned SYNC_DEPTH = 3;
  localparam int unsigned PIN_W      = 11;
  localparam int unsigned PIN_SCLK   = 0;
  localparam int unsigned PIN_SDA    = 1;
  localparam int unsigned PIN_CSN    = 2;
  localparam int unsigned PIN_A1     = 3;
  localparam int unsigned PIN_ISEL   = 4;
  localparam int unsigned PIN_PDN    = 5;
  localparam int unsigned PIN_DRST   = 6;
  localparam int unsigned PIN_OED    = 7;
  localparam int unsigned PIN_SYNC   = 8;
  localparam int unsigned PIN_INS0   = 9;
  localparam int unsigned PIN_INS1   = 10;
  // level each pin rests at when left open (internal pulls)
  localparam logic [PIN_W-1:0] PIN_IDLE = 11'h177;

  // ==========================================================
  // sizes
  localparam int unsigned N_OUT = 12;
  localparam int unsigned MON_W = 2;

  // ==========================================================
  // register map and fields
  localparam logic [7:0] REG_STATUS    = 8'h00;
  localparam logic [7:0] REG_FLAGS     = 8'h01;
  localparam logic [7:0] REG_CTRL      = 8'h02;
  localparam logic [7:0] CTRL_RST      = 8'h00;
  localparam logic [7:0] BYTE_ZERO     = 8'h00;
  localparam logic [7:0] PTR_STEP      = 8'h01;
  localparam int unsigned CTRL_SOFT_DIS = 0;
  localparam int unsigned CTRL_3WIRE    = 1;
  localparam int unsigned SPI_RD_BIT    = 7;
  // upper five bits of the I2C slave address, arbitrary value
  localparam logic [4:0] I2C_ADDR_HI   = 5'h0D;
  localparam logic [2:0] BIT_FIRST     = 3'h0;
  localparam logic [2:0] BIT_LAST      = 3'h7;
  localparam logic [2:0] BIT_STEP      = 3'h1;

  // ==========================================================
  // serial engine states
  typedef enum logic [8:0] {
    ST_IDLE   = 9'h001,
    ST_DEVADR = 9'h002,
    ST_DEVACK = 9'h004,
    ST_REG    = 9'h008,
    ST_REGACK = 9'h010,
    ST_WDATA  = 9'h020,
    ST_WACK   = 9'h040,
    ST_RDATA  = 9'h080,
    ST_RACK   = 9'h100
  } state_t;

endpackage
`default_nettype wire

/* hdl/pin_lvl_if.sv */
// carrier of raw and filtered pin levels between the control modules
`timescale 1ns/100ps
`default_nettype none
interface pin_lvl_if #(
  parameter int unsigned W = 1
);
  logic [W-1:0] raw;
  logic [W-1:0] lvl;
  modport filter  (input raw, output lvl);
  modport owner   (output raw, input lvl);
  modport watcher (input lvl);
endinterface
`default_nettype wire

/* hdl/pin_sync.sv */
// three-stage synchroniser with agreement filter for asynchronous pins
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int unsigned W    = 1,
  parameter logic [W-1:0] IDLE = '0
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  pin_lvl_if.filter p
);
  import clkgen_pins_pkg::*;

  if (W < 1) begin
    $error("pin_sync needs at least one pin");
  end

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } sync_t;

  localparam sync_t SYNC_RST = '{s1: IDLE, s2: IDLE, s3: IDLE, lvl: IDLE};

  sync_t q;
  sync_t d;

  // =========================================================
  // stage chain; a level counts once stages two and three agree
  always_comb begin
    d     = q;
    d.s1  = p.raw;
    d.s2  = q.s1;
    d.s3  = q.s2;
    d.lvl = (q.s2 & q.s3) | (q.lvl & (q.s2 | q.s3));
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= SYNC_RST;
    end else begin
      q <= d;
    end
  end

  assign p.lvl = q.lvl;

endmodule
`default_nettype wire

/* hdl/clk_out_ctrl.sv */
// output enables, divider realign, power-down and reference selection
`timescale 1ns/100ps
`default_nettype none
module clk_out_ctrl #(
  parameter int unsigned N = clkgen_pins_pkg::N_OUT
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  pin_lvl_if.watcher        pins,
  input  wire logic         soft_disable_i,
  input  wire logic         dev_rst_i,
  output logic [N-1:0]      clk_out_enable_o,
  output logic              divider_reset_o,
  output logic              low_power_o,
  output logic [1:0]        active_ref_o
);
  import clkgen_pins_pkg::*;

  if (N < 1) begin
    $error("clk_out_ctrl needs at least one output");
  end

  typedef struct packed {
    logic [N-1:0] en;
    logic         div_rst;
    logic         low_pwr;
    logic [1:0]   ref_sel;
  } out_t;

  localparam out_t OUT_RST = '{en: '0, div_rst: 1'b1, low_pwr: 1'b0, ref_sel: 2'h0};

  out_t q;
  out_t d;

  // =========================================================
  // output pin decisions
  always_comb begin
    d = q;
    d.en = (dev_rst_i || pins.lvl[PIN_OED] || soft_disable_i) ? '0 : '1;
    d.div_rst = !pins.lvl[PIN_SYNC] || dev_rst_i;
    d.low_pwr = !pins.lvl[PIN_PDN];
    d.ref_sel = {pins.lvl[PIN_INS1], pins.lvl[PIN_INS0]};
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= OUT_RST;
    end else begin
      q <= d;
    end
  end

  assign clk_out_enable_o = q.en;
  assign divider_reset_o  = q.div_rst;
  assign low_power_o      = q.low_pwr;
  assign active_ref_o     = q.ref_sel;

endmodule
`default_nettype wire

/* hdl/clkgen_pin_ctrl.sv */
// top level: serial host port, status change flags and discrete control pins
`timescale 1ns/100ps
`default_nettype none
module clkgen_pin_ctrl #(
  parameter int unsigned N_OUTPUTS = clkgen_pins_pkg::N_OUT,
  parameter int unsigned MON_BITS  = clkgen_pins_pkg::MON_W
) (
  input  wire logic                 sys_clk_i,
  input  wire logic                 reset_n_i,
  input  wire logic                 serial_if_select_i,
  input  wire logic                 sclk_i,
  input  wire logic                 sda_i,
  output logic                      sda_o,
  output logic                      sda_oe_o,
  input  wire logic                 addr1_or_serial_out_i,
  output logic                      addr1_or_serial_out_o,
  output logic                      addr1_or_serial_out_oe_o,
  input  wire logic                 addr0_or_chip_select_n_i,
  input  wire logic                 power_down_n_i,
  input  wire logic                 device_reset_n_i,
  input  wire logic                 outputs_disable_i,
  input  wire logic                 divider_realign_n_i,
  input  wire logic [1:0]           ref_select_i,
  input  wire logic                 pll_locked_i,
  input  wire logic [MON_BITS-1:0]  mon_status_i,
  output logic                      status_change_irq_n_o,
  output logic                      pll_locked_flag_o,
  output logic [N_OUTPUTS-1:0]      clk_out_enable_o,
  output logic                      divider_reset_o,
  output logic                      low_power_o,
  output logic [1:0]                active_ref_o
);
  import clkgen_pins_pkg::*;

  localparam int unsigned STAT_W = MON_BITS + 1;

  if (STAT_W > 8 || N_OUTPUTS < 1) begin
    $error("clkgen_pin_ctrl: status must fit one byte, outputs at least one");
  end

  typedef struct packed {
    state_t            st;
    logic [2:0]        bits;
    logic [7:0]        sh;
    logic [7:0]        ptr;
    logic              rw;
    logic [7:0]        ctrl;
    logic [STAT_W-1:0] flags;
    logic [STAT_W-1:0] stat;
    logic              scl;
    logic              sda;
    logic              csn;
    logic              dout;
    logic              doe;
    logic              irq_n;
    logic              lock;
  } regs_t;

  localparam regs_t REGS_RST = '{
    st:    ST_IDLE,
    bits:  BIT_FIRST,
    sh:    BYTE_ZERO,
    ptr:   BYTE_ZERO,
    rw:    1'b0,
    ctrl:  CTRL_RST,
    flags: '0,
    stat:  '0,
    scl:   1'b1,
    sda:   1'b1,
    csn:   1'b1,
    dout:  1'b1,
    doe:   1'b0,
    irq_n: 1'b1,
    lock:  1'b0
  };

  regs_t q;
  regs_t d;

  // ==========================================================
  // pin synchronisation
  pin_lvl_if #(.W(PIN_W)) pins ();

  assign pins.raw = {
    ref_select_i[1],
    ref_select_i[0],
    divider_realign_n_i,
    outputs_disable_i,
    device_reset_n_i,
    power_down_n_i,
    serial_if_select_i,
    addr1_or_serial_out_i,
    addr0_or_chip_select_n_i,
    sda_i,
    sclk_i
  };

  pin_sync #(
    .W    (PIN_W),
    .IDLE (PIN_IDLE)
  ) u_pin_sync (
    .clk_i   (sys_clk_i),
    .rst_n_i (reset_n_i),
    .p       (pins)
  );

  // ==========================================================
  // register read decode, shared by both protocols
  function automatic logic [7:0] rd_byte(
    input logic [7:0]       a,
    input regs_t            r,
    input logic [PIN_W-1:0] l
  );
    logic [7:0] v;
    v = BYTE_ZERO;
    case (a)
      REG_STATUS: v = {4'h0, l[PIN_INS1], l[PIN_INS0], l[PIN_PDN], r.lock};
      REG_FLAGS:  v = 8'(r.flags);
      REG_CTRL:   v = r.ctrl;
      default:    v = BYTE_ZERO;
    endcase
    return v;
  endfunction

  // ==========================================================
  // line conditions
  logic              i2c_mode;
  logic              scl;
  logic              sda;
  logic              csn;
  logic              scl_rise;
  logic              scl_fall;
  logic              i2c_start;
  logic              i2c_stop;
  logic              byte_done;
  logic              spi_3w;
  logic              dev_rst;
  logic              addr_hit;
  logic [7:0]        byte_in;
  logic [7:0]        rd_now;
  logic [7:0]        rd_next;
  logic [STAT_W-1:0] stat_now;
  logic [STAT_W-1:0] flag_clr;

  assign i2c_mode  = pins.lvl[PIN_ISEL];
  assign scl       = pins.lvl[PIN_SCLK];
  assign sda       = pins.lvl[PIN_SDA];
  assign csn       = pins.lvl[PIN_CSN];
  assign dev_rst   = !pins.lvl[PIN_DRST];
  assign spi_3w    = q.ctrl[CTRL_3WIRE];
  assign scl_rise  = scl && !q.scl;
  assign scl_fall  = !scl && q.scl;
  assign i2c_start = scl && q.scl && q.sda && !sda;
  assign i2c_stop  = scl && q.scl && !q.sda && sda;
  assign byte_in   = {q.sh[6:0], sda};
  assign byte_done = scl_rise && (q.bits == BIT_LAST);
  assign addr_hit  = byte_in[7:1] == {I2C_ADDR_HI, pins.lvl[PIN_A1], pins.lvl[PIN_CSN]};
  assign rd_now    = rd_byte(q.ptr, q, pins.lvl);
  assign rd_next   = rd_byte(q.ptr + PTR_STEP, q, pins.lvl);
  assign stat_now  = {mon_status_i, pll_locked_i};
  assign flag_clr  = (q.st == ST_WDATA && byte_done && q.ptr == REG_FLAGS)
                   ? byte_in[STAT_W-1:0] : '0;

  // ==========================================================
  // next state
  always_comb begin
    d      = q;
    d.scl  = scl;
    d.sda  = sda;
    d.csn  = csn;
    d.lock = pll_locked_i;
    d.stat = stat_now;
    // a change in the same cycle as a clear keeps its flag
    d.flags = (q.flags & ~flag_clr) | (stat_now ^ q.stat);
    d.irq_n = ~|d.flags;

    if (scl_rise && (q.st == ST_DEVADR || q.st == ST_REG || q.st == ST_WDATA)) begin
      d.sh   = byte_in;
      d.bits = q.bits + BIT_STEP;
    end

    case (q.st)
      ST_IDLE: begin
        d.doe = 1'b0;
      end
      ST_DEVADR: begin
        if (byte_done) begin
          d.rw = byte_in[0];
          d.st = addr_hit ? ST_DEVACK : ST_IDLE;
        end
      end
      ST_DEVACK, ST_REGACK, ST_WACK: begin
        if (scl_fall && !q.doe) begin
          d.doe  = 1'b1;
          d.dout = 1'b0;
        end else if (scl_fall) begin
          d.doe  = 1'b0;
          d.dout = 1'b1;
          d.bits = BIT_FIRST;
          d.st   = (q.st == ST_DEVACK) ? ST_REG : ST_WDATA;
          if (q.st == ST_DEVACK && q.rw) begin
            d.st   = ST_RDATA;
            d.sh   = rd_now;
            d.doe  = 1'b1;
            d.dout = rd_now[7];
          end
        end
      end
      ST_REG: begin
        if (byte_done && i2c_mode) begin
          d.ptr = byte_in;
          d.st  = ST_REGACK;
        end else if (byte_done) begin
          d.rw  = byte_in[SPI_RD_BIT];
          d.ptr = {1'b0, byte_in[6:0]};
          d.st  = byte_in[SPI_RD_BIT] ? ST_RDATA : ST_WDATA;
          d.sh  = rd_byte({1'b0, byte_in[6:0]}, q, pins.lvl);
        end
      end
      ST_WDATA: begin
        if (byte_done) begin
          if (q.ptr == REG_CTRL) begin
            d.ctrl = byte_in;
          end
          d.ptr = q.ptr + PTR_STEP;
          d.st  = i2c_mode ? ST_WACK : ST_WDATA;
        end
      end
      ST_RDATA: begin
        if (scl_fall) begin
          d.doe = 1'b1;
          if (q.bits == BIT_FIRST) begin
            d.dout = q.sh[7];
          end else begin
            d.sh   = {q.sh[6:0], 1'b0};
            d.dout = q.sh[6];
          end
        end
        if (scl_rise) begin
          d.bits = q.bits + BIT_STEP;
        end
        if (byte_done) begin
          d.ptr = q.ptr + PTR_STEP;
          if (i2c_mode) begin
            d.st = ST_RACK;
          end else begin
            d.sh = rd_next;
          end
        end
      end
      ST_RACK: begin
        if (scl_fall) begin
          d.doe  = 1'b0;
          d.dout = 1'b1;
        end
        if (scl_rise && sda) begin
          d.st = ST_IDLE;
        end else if (scl_rise) begin
          d.st   = ST_RDATA;
          d.sh   = rd_now;
          d.bits = BIT_FIRST;
        end
      end
      default: begin
        d.st  = ST_IDLE;
        d.doe = 1'b0;
      end
    endcase

    // framing wins over the byte engine
    if (!i2c_mode) begin
      if (csn) begin
        d.st  = ST_IDLE;
        d.doe = 1'b0;
      end else if (q.csn) begin
        d.st   = ST_REG;
        d.bits = BIT_FIRST;
        d.doe  = 1'b0;
      end
    end else if (i2c_stop) begin
      d.st  = ST_IDLE;
      d.doe = 1'b0;
    end else if (i2c_start) begin
      d.st   = ST_DEVADR;
      d.bits = BIT_FIRST;
      d.doe  = 1'b0;
    end

    if (dev_rst) begin
      d      = REGS_RST;
      d.stat = stat_now;
      // track live line levels so release sees no false edge or start
      d.scl  = scl;
      d.sda  = sda;
      d.csn  = csn;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      q <= REGS_RST;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // serial pins: open drain in I2C, push-pull in SPI
  assign sda_o                    = q.dout;
  assign sda_oe_o                 = q.doe && (i2c_mode ? !q.dout : spi_3w);
  assign addr1_or_serial_out_o    = q.dout;
  assign addr1_or_serial_out_oe_o = q.doe && !i2c_mode && !spi_3w;
  assign status_change_irq_n_o    = q.irq_n;
  assign pll_locked_flag_o        = q.lock;

  // ==========================================================
  // clock output side
  clk_out_ctrl #(
    .N (N_OUTPUTS)
  ) u_clk_out_ctrl (
    .clk_i            (sys_clk_i),
    .rst_n_i          (reset_n_i),
    .pins             (pins),
    .soft_disable_i   (q.ctrl[CTRL_SOFT_DIS]),
    .dev_rst_i        (dev_rst),
    .clk_out_enable_o (clk_out_enable_o),
    .divider_reset_o  (divider_reset_o),
    .low_power_o      (low_power_o),
    .active_ref_o     (active_ref_o)
  );

endmodule
`default_nettype wire

/* verification/host_model.sv */
// host controller model: drives the serial port as I2C or SPI master
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input  wire logic sys_clk_i,
  input  wire logic sda_i,
  input  wire logic so_i,
  output logic      sclk_o,
  output logic      sda_o,
  output logic      csn_o
);
  // set by the bench: read the shared data pin in 3-wire SPI frames
  logic three_wire;
  initial begin
    three_wire = 1'b0;
    sclk_o = 1'b1;
    sda_o  = 1'b1;
    csn_o  = 1'b1;
  end
  // half a serial clock period, well above the five-cycle minimum phase
  task automatic half();
    repeat (8) @(negedge sys_clk_i);
  endtask
  // ==========================================================
  // one byte msb first, data changed while the clock is low
  task automatic shift(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      sda_o = b[i];
      half();
      sclk_o = 1'b1;
      r[i] = (csn_o || three_wire) ? sda_i : so_i;
      half();
      sclk_o = 1'b0;
    end
  endtask
  task automatic i2c_byte(input logic [7:0] b, output logic k);
    logic [7:0] r;
    shift(b, r);
    sda_o = 1'b1;
    half();
    sclk_o = 1'b1;
    k = !sda_i;
    half();
    sclk_o = 1'b0;
  endtask
  // ==========================================================
  // I2C register write; k holds the three acknowledge bits in order
  task automatic i2c_wr(input logic [7:0] a, input logic [7:0] g, input logic [7:0] d,
                        output logic [2:0] k);
    sclk_o = 1'b1;
    sda_o = 1'b1;
    half();
    sda_o = 1'b0;
    half();
    sclk_o = 1'b0;
    i2c_byte(a, k[2]);
    i2c_byte(g, k[1]);
    i2c_byte(d, k[0]);
    sda_o = 1'b0;
    half();
    sclk_o = 1'b1;
    half();
    sda_o = 1'b1;
    half();
  endtask
  // SPI frame of a command byte and one data byte, mode 0
  task automatic spi_xfer(input logic [7:0] c, input logic [7:0] d, output logic [7:0] r);
    sclk_o = 1'b0;
    half();
    csn_o = 1'b0;
    half();
    shift(c, r);
    shift(d, r);
    half();
    csn_o = 1'b1;
    sda_o = ~sda_o;
  endtask
endmodule
`default_nettype wire

/* verification/clkgen_pin_ctrl_monitor.sv */
// concurrent checks on the clock generator control pins
`timescale 1ns/100ps
`default_nettype none
module clkgen_pin_ctrl_monitor #(
  parameter int unsigned N_OUTPUTS = 12,
  parameter int unsigned MON_BITS  = 2
) (
  input wire logic                 sys_clk_i,
  input wire logic                 reset_n_i,
  input wire logic                 serial_if_select_i,
  input wire logic                 sclk_i,
  input wire logic                 sda_o,
  input wire logic                 sda_oe_o,
  input wire logic                 addr1_or_serial_out_oe_o,
  input wire logic                 addr0_or_chip_select_n_i,
  input wire logic                 power_down_n_i,
  input wire logic                 device_reset_n_i,
  input wire logic                 outputs_disable_i,
  input wire logic                 divider_realign_n_i,
  input wire logic [1:0]           ref_select_i,
  input wire logic                 pll_locked_i,
  input wire logic                 status_change_irq_n_o,
  input wire logic                 pll_locked_flag_o,
  input wire logic [N_OUTPUTS-1:0] clk_out_enable_o,
  input wire logic                 divider_reset_o,
  input wire logic                 low_power_o,
  input wire logic [1:0]           active_ref_o
);
  // cycles since the serial clock last moved and device reset was low
  logic       sclk_q;
  logic [4:0] quiet_q;
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sclk_q  <= 1'b1;
      quiet_q <= 5'h00;
    end else begin
      sclk_q <= sclk_i;
      if (sclk_i != sclk_q || !device_reset_n_i) begin
        quiet_q <= 5'h00;
      end else if (quiet_q != 5'h1F) begin
        quiet_q <= quiet_q + 5'h01;
      end
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  a_disable_pin_off: assert property (
    outputs_disable_i [*7] |-> clk_out_enable_o == '0) else $error("outputs left on");
  a_realign_resets: assert property (
    !divider_realign_n_i [*7] |-> divider_reset_o) else $error("dividers not reset");
  a_power_down_follows: assert property (
    $stable(power_down_n_i) [*8] |-> low_power_o == !power_down_n_i)
    else $error("low power state wrong");
  a_ref_follows_pins: assert property (
    $stable(ref_select_i) [*8] |-> active_ref_o == ref_select_i) else $error("wrong reference");
  a_lock_flag_level: assert property (
    $stable(pll_locked_i) [*2] |-> pll_locked_flag_o == pll_locked_i) else $error("lock flag wrong");
  a_irq_on_change: assert property (
    device_reset_n_i && pll_locked_i != $past(pll_locked_i) |-> ##[1:3] !status_change_irq_n_o)
    else $error("no interrupt after lock change");
  a_irq_held_low: assert property (
    quiet_q > 5'h0C && !status_change_irq_n_o |=> !status_change_irq_n_o)
    else $error("interrupt released without host clear");
  a_i2c_open_drain: assert property (
    serial_if_select_i [*8] ##0 sda_oe_o |-> !sda_o) else $error("data pin driven high in I2C");
  a_i2c_no_serial_out: assert property (
    serial_if_select_i [*8] |-> !addr1_or_serial_out_oe_o) else $error("serial out driven in I2C");
  a_deselect_quiet: assert property (
    (!serial_if_select_i && addr0_or_chip_select_n_i) [*8] |-> !addr1_or_serial_out_oe_o && !sda_oe_o)
    else $error("pins driven while deselected");
  a_dev_reset_state: assert property (
    !device_reset_n_i [*7] |-> clk_out_enable_o == '0 && divider_reset_o && status_change_irq_n_o)
    else $error("device reset state wrong");
endmodule
bind clkgen_pin_ctrl clkgen_pin_ctrl_monitor #(
  .N_OUTPUTS(N_OUTPUTS),
  .MON_BITS (MON_BITS)
) monitor_i (.*);
`default_nettype wire

/* verification/testbench.sv */
// self-checking bench for the clock generator control pin block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) \
  begin \
    check_count++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("mismatch %s expected %0h seen %0h", nm, exp, got); \
    end \
  end
module testbench;
  import clkgen_pins_pkg::*;
  localparam logic [11:0] ALL_ON = 12'hFFF;
  logic        clk, rst_n, sel, sclk, host_sda, csn, pdn, drst_n, oe_dis, realign_n, locked;
  logic [1:0]  ref_sel, mon, act_ref;
  logic        sda_o, sda_oe, a1_o, a1_oe, irq_n, lock_flag, div_rst, low_pwr;
  logic [11:0] en;
  logic        sda_w, a1_w;
  int          mismatches, check_count;
  // open-drain data line with pull-up; address pin pulled down when undriven
  assign sda_w = host_sda & (sda_oe ? sda_o : 1'b1);
  assign a1_w  = a1_oe ? a1_o : 1'b0;
  always #20 clk = ~clk;
  host_model host_i (.sys_clk_i(clk), .sda_i(sda_w), .so_i(a1_w), .sclk_o(sclk),
    .sda_o(host_sda), .csn_o(csn));
  clkgen_pin_ctrl clkgen_pin_ctrl_i (.sys_clk_i(clk), .reset_n_i(rst_n),
    .serial_if_select_i(sel), .sclk_i(sclk), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe),
    .addr1_or_serial_out_i(a1_w), .addr1_or_serial_out_o(a1_o),
    .addr1_or_serial_out_oe_o(a1_oe), .addr0_or_chip_select_n_i(csn), .power_down_n_i(pdn),
    .device_reset_n_i(drst_n), .outputs_disable_i(oe_dis), .divider_realign_n_i(realign_n),
    .ref_select_i(ref_sel), .pll_locked_i(locked), .mon_status_i(mon),
    .status_change_irq_n_o(irq_n), .pll_locked_flag_o(lock_flag), .clk_out_enable_o(en),
    .divider_reset_o(div_rst), .low_power_o(low_pwr), .active_ref_o(act_ref));
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask
  // ==========================================================
  task automatic t_discrete();
    `CHK("enables", ALL_ON, en);
    `CHK("divider reset", 1'b0, div_rst);
    `CHK("active ref", 2'h0, act_ref);
    `CHK("irq", 1'b1, irq_n);
    oe_dis = 1'b1;
    realign_n = 1'b0;
    pdn = 1'b0;
    w(8);
    `CHK("enables", 12'h000, en);
    `CHK("divider reset", 1'b1, div_rst);
    `CHK("low power", 1'b1, low_pwr);
    oe_dis = 1'b0;
    realign_n = 1'b1;
    pdn = 1'b1;
    w(8);
    `CHK("enables", ALL_ON, en);
    `CHK("low power", 1'b0, low_pwr);
    for (int i = 3; i >= 0; i--) begin
      ref_sel = 2'(i);
      w(8);
      `CHK("active ref", 2'(i), act_ref);
    end
  endtask
  // ==========================================================
  task automatic t_i2c();
    logic [2:0] k;
    host_i.i2c_wr({I2C_ADDR_HI, 2'b01, 1'b0}, REG_CTRL, 8'h01, k);
    `CHK("i2c acks", 3'h7, k);
    w(8);
    `CHK("soft disable", 12'h000, en);
    host_i.i2c_wr({I2C_ADDR_HI, 2'b11, 1'b0}, REG_CTRL, 8'h00, k);
    `CHK("foreign acks", 3'h0, k);
    `CHK("soft disable kept", 12'h000, en);
    drst_n = 1'b0;
    w(10);
    `CHK("divider reset", 1'b1, div_rst);
    drst_n = 1'b1;
    w(10);
    `CHK("enables", ALL_ON, en);
  endtask
  // ==========================================================
  task automatic t_spi();
    logic [7:0] r;
    sel = 1'b0;
    w(8);
    locked = 1'b1;
    w(4);
    `CHK("lock flag", 1'b1, lock_flag);
    `CHK("irq", 1'b0, irq_n);
    host_i.spi_xfer({1'b1, REG_STATUS[6:0]}, BYTE_ZERO, r);
    `CHK("status read", 8'h03, r);
    host_i.spi_xfer({1'b0, REG_FLAGS[6:0]}, 8'hFF, r);
    w(8);
    `CHK("irq", 1'b1, irq_n);
    mon = 2'h2;
    w(30);
    `CHK("irq", 1'b0, irq_n);
    host_i.spi_xfer({1'b0, REG_FLAGS[6:0]}, 8'hFF, r);
    w(8);
    `CHK("irq", 1'b1, irq_n);
    locked = 1'b0;
    w(4);
    `CHK("lock flag", 1'b0, lock_flag);
    // switch to 3-wire: read data comes back on the shared data pin
    host_i.spi_xfer({1'b0, REG_CTRL[6:0]}, 8'h02, r);
    host_i.three_wire = 1'b1;
    host_i.spi_xfer({1'b1, REG_FLAGS[6:0]}, 8'hFF, r);
    `CHK("three-wire flags read", 8'h01, r);
    `CHK("irq", 1'b0, irq_n);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    sel = 1'b1;
    pdn = 1'b1;
    drst_n = 1'b1;
    oe_dis = 1'b0;
    realign_n = 1'b1;
    ref_sel = 2'h0;
    locked = 1'b0;
    mon = 2'h0;
    mismatches = 0;
    check_count = 0;
    repeat (6) @(posedge clk);
    w(1);
    rst_n = 1'b1;
    w(12);
    t_discrete();
    t_i2c();
    t_spi();
    close_out();
  end
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    close_out();
  end
endmodule
`default_nettype wire
